// ---- core/lsc_defines.vh ----
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH
`define LSC_ADDR_W        14
`define LSC_DATA_W        16
`define LSC_BYTE_W        8
`define LSC_CLK_PERIOD_NS 8
`define LSC_T_SETUP_NS    20
`define LSC_T_PULSE_NS    20
`define LSC_T_ACCESS_NS   25
`define LSC_T_HOLD_NS     10
`define LSC_SYNC_CYC      2
`define LSC_CYC(ns)       (((ns) + `LSC_CLK_PERIOD_NS - 1) / `LSC_CLK_PERIOD_NS)
`define LSC_CNT_W         4
`endif

// ---- core/lsc_sync2.v ----
`timescale 1ns/1ns
module lsc_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // lsc_sync2

// ---- core/lsc_ctrl.v ----
`timescale 1ns/1ns
`include "lsc_defines.vh"
module lsc_ctrl (
  input  wire                     clk,
  input  wire                     resetn,
  input  wire                     req_valid,
  input  wire                     req_write,
  input  wire [`LSC_ADDR_W-1:0]   req_addr,
  input  wire [`LSC_DATA_W-1:0]   req_wdata,
  input  wire [1:0]               req_be,
  output reg                      req_ready,
  output reg                      rsp_valid,
  output reg  [`LSC_DATA_W-1:0]   rsp_rdata,
  output reg  [`LSC_ADDR_W-1:0]   word_address,
  output reg                      sel_hi,
  output reg                      sel_lo_n,
  output reg                      write_n,
  output reg                      out_en_n,
  output reg                      low_byte_strobe_n,
  output reg                      high_byte_strobe_n,
  output reg                      addr_latch_open,
  output reg                      wdata_latch_open,
  input  wire [`LSC_DATA_W-1:0]   data_io_bus_in,
  output reg  [`LSC_DATA_W-1:0]   data_io_bus_out,
  output reg                      data_io_bus_oe
);
  localparam [4:0] ST_IDLE  = 5'b00001;
  localparam [4:0] ST_SETUP = 5'b00010;
  localparam [4:0] ST_PULSE = 5'b00100;
  localparam [4:0] ST_READ  = 5'b01000;
  localparam [4:0] ST_HOLD  = 5'b10000;
  // counts are worked out in ns, then cut to the counter width; all fit in four bits
  localparam integer          N_SETUP_I  = `LSC_CYC(`LSC_T_SETUP_NS);
  localparam integer          N_PULSE_I  = `LSC_CYC(`LSC_T_PULSE_NS);
  localparam integer          N_ACCESS_I = `LSC_CYC(`LSC_T_ACCESS_NS) + `LSC_SYNC_CYC;
  localparam integer          N_HOLD_I   = `LSC_CYC(`LSC_T_HOLD_NS);
  localparam [`LSC_CNT_W-1:0] N_SETUP    = N_SETUP_I[`LSC_CNT_W-1:0];
  localparam [`LSC_CNT_W-1:0] N_PULSE    = N_PULSE_I[`LSC_CNT_W-1:0];
  localparam [`LSC_CNT_W-1:0] N_ACCESS   = N_ACCESS_I[`LSC_CNT_W-1:0];
  localparam [`LSC_CNT_W-1:0] N_HOLD     = N_HOLD_I[`LSC_CNT_W-1:0];

  reg                    rst_m_q;
  reg                    rst_n_q;
  reg  [4:0]             state_q;
  reg  [`LSC_CNT_W-1:0]  cnt_q;
  reg                    wr_q;
  reg  [1:0]             req_be_q;
  wire [`LSC_DATA_W-1:0] rd_sync;
  wire                   take;
  wire [1:0]             lane_strobe_n;

  // a request is taken only in idle while ready is up
  assign take = (state_q == ST_IDLE) && req_valid && req_ready;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_lane
      assign lane_strobe_n[i] = ~req_be_q[i];
    end
  endgenerate

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // pins from the memory are asynchronous to clk
  lsc_sync2 #(
    .W (`LSC_DATA_W)
  ) u_rd_sync (
    .clk   (clk),
    .rst_n (rst_n_q),
    .din   (data_io_bus_in),
    .dout  (rd_sync)
  );

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q            <= ST_IDLE;
      cnt_q              <= 4'h0;
      wr_q               <= 1'b0;
      req_ready          <= 1'b0;
      rsp_valid          <= 1'b0;
      rsp_rdata          <= 16'h0000;
      word_address       <= 14'h0000;
      sel_hi             <= 1'b0;
      sel_lo_n           <= 1'b1;
      write_n            <= 1'b1;
      out_en_n           <= 1'b1;
      low_byte_strobe_n  <= 1'b1;
      high_byte_strobe_n <= 1'b1;
      addr_latch_open    <= 1'b1;
      wdata_latch_open   <= 1'b1;
      data_io_bus_out    <= 16'h0000;
      data_io_bus_oe     <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          req_ready          <= 1'b1;
          write_n            <= 1'b1;
          low_byte_strobe_n  <= 1'b1;
          high_byte_strobe_n <= 1'b1;
          if (take) begin
            req_ready       <= 1'b0;
            word_address    <= req_addr;
            wr_q            <= req_write;
            data_io_bus_out <= req_wdata;
            sel_hi          <= 1'b1;
            sel_lo_n        <= 1'b0;
            cnt_q           <= N_SETUP;
            if (req_write) begin
              // output enable stays high on writes
              out_en_n       <= 1'b1;
              data_io_bus_oe <= 1'b1;
              state_q        <= ST_SETUP;
            end else begin
              write_n        <= 1'b1;
              out_en_n       <= 1'b0;
              cnt_q          <= N_ACCESS;
              state_q        <= ST_READ;
            end
          end
        end
        ST_SETUP: begin
          if (cnt_q == 4'h1) begin
            low_byte_strobe_n  <= lane_strobe_n[0];
            high_byte_strobe_n <= lane_strobe_n[1];
            write_n            <= 1'b0;
            cnt_q              <= N_PULSE;
            state_q            <= ST_PULSE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_PULSE: begin
          if (cnt_q == 4'h1) begin
            write_n            <= 1'b1;
            low_byte_strobe_n  <= 1'b1;
            high_byte_strobe_n <= 1'b1;
            cnt_q              <= N_HOLD;
            state_q            <= ST_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_READ: begin
          if (cnt_q == 4'h1) begin
            rsp_rdata <= rd_sync;
            rsp_valid <= 1'b1;
            out_en_n  <= 1'b1;
            cnt_q     <= N_HOLD;
            state_q   <= ST_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_HOLD: begin
          sel_hi   <= 1'b0;
          sel_lo_n <= 1'b1;
          if (cnt_q == 4'h1) begin
            data_io_bus_oe <= 1'b0;
            rsp_valid      <= wr_q;
            state_q        <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          // a broken one-hot code parks the selects, strobes and bus enable inactive and drops ready before retrying from idle
          state_q            <= ST_IDLE;
          req_ready          <= 1'b0;
          sel_hi             <= 1'b0;
          sel_lo_n           <= 1'b1;
          write_n            <= 1'b1;
          out_en_n           <= 1'b1;
          low_byte_strobe_n  <= 1'b1;
          high_byte_strobe_n <= 1'b1;
          data_io_bus_oe     <= 1'b0;
        end
      endcase
    end
  end

  // byte enables captured with the request, since the port may change
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      req_be_q <= 2'b00;
    end else if (take) begin
      req_be_q <= req_be;
    end
  end
endmodule // lsc_ctrl

// ---- sim/lsc_sram_model.sv ----
`timescale 1ns/1ns
module lsc_sram_model (
  input  logic        clk,
  input  logic [13:0] word_address,
  input  logic        sel_hi,
  input  logic        sel_lo_n,
  input  logic        write_n,
  input  logic        out_en_n,
  input  logic        low_byte_strobe_n,
  input  logic        high_byte_strobe_n,
  input  logic        addr_latch_open,
  input  logic        wdata_latch_open,
  input  logic [15:0] ctl_data,
  input  logic        ctl_oe,
  output logic [15:0] data_bus
);
  logic [15:0] mem [0:16383];
  logic [13:0] addr_l;
  logic [15:0] wdata_l;
  logic        sel_l;
  logic [15:0] last_q = 16'h0000;
  always_latch if (addr_latch_open) begin
    addr_l <= word_address;
    sel_l <= sel_hi & ~sel_lo_n;
  end
  always_latch if (wdata_latch_open) wdata_l <= ctl_data;
  always @* begin
    if (sel_l && !write_n && !low_byte_strobe_n) mem[addr_l][7:0] = wdata_l[7:0];
    if (sel_l && !write_n && !high_byte_strobe_n) mem[addr_l][15:8] = wdata_l[15:8];
  end
  wire drv = sel_l && write_n && !out_en_n;
  // floating bus toggles so a stale value never reads as good
  always @(posedge clk) last_q <= data_bus;
  assign data_bus = ctl_oe ? ctl_data : drv ? mem[addr_l] : ~last_q;
endmodule // lsc_sram_model

// ---- sim/lsc_ctrl_asserts.sv ----
`timescale 1ns/1ns
module lsc_ctrl_asserts (
  input logic        clk,
  input logic        resetn,
  input logic [13:0] word_address,
  input logic        sel_hi,
  input logic        sel_lo_n,
  input logic        write_n,
  input logic        out_en_n,
  input logic        low_byte_strobe_n,
  input logic        high_byte_strobe_n,
  input logic        addr_latch_open,
  input logic        wdata_latch_open,
  input logic [15:0] data_io_bus_out,
  input logic        data_io_bus_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_latch_open: assert property (addr_latch_open && wdata_latch_open)
    else $error("latch enable dropped");
  a_read_no_wr: assert property (!out_en_n |-> write_n)
    else $error("write strobe low in read");
  a_addr_wr_hi: assert property ($changed(word_address) |-> write_n && $past(write_n))
    else $error("address moved under write");
  a_wr_sel: assert property (!write_n |-> sel_hi && !sel_lo_n)
    else $error("write while deselected");
  a_wr_hold: assert property (!write_n && $past(!write_n) |->
    $stable(word_address) && $stable(data_io_bus_out) && data_io_bus_oe)
    else $error("write inputs not held");
  c_abort: cover property (!write_n && low_byte_strobe_n && high_byte_strobe_n);
  c_low_lane: cover property (!write_n && !low_byte_strobe_n && high_byte_strobe_n);
  c_read: cover property (!out_en_n);
endmodule // lsc_ctrl_asserts

// ---- sim/lsc_ctrl_test.sv ----
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module lsc_ctrl_test;
  logic clk = 0, resetn = 0, req_valid = 0, req_write = 0;
  logic [13:0] req_addr = 14'h0000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0] req_be = 2'h0;
  wire req_ready, rsp_valid, sel_hi, sel_lo_n, write_n, out_en_n, lbs_n, hbs_n, ale, dle, bus_oe;
  wire [15:0] rsp_rdata, bus_out, bus;
  wire [13:0] word_address;
  integer failures = 0, compares = 0, cycles = 0;
  lsc_ctrl DUT (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .word_address(word_address), .sel_hi(sel_hi),
    .sel_lo_n(sel_lo_n), .write_n(write_n), .out_en_n(out_en_n), .low_byte_strobe_n(lbs_n),
    .high_byte_strobe_n(hbs_n), .addr_latch_open(ale), .wdata_latch_open(dle),
    .data_io_bus_in(bus), .data_io_bus_out(bus_out), .data_io_bus_oe(bus_oe));
  lsc_sram_model mem (.clk(clk), .word_address(word_address), .sel_hi(sel_hi), .sel_lo_n(sel_lo_n),
    .write_n(write_n), .out_en_n(out_en_n), .low_byte_strobe_n(lbs_n), .high_byte_strobe_n(hbs_n),
    .addr_latch_open(ale), .wdata_latch_open(dle), .ctl_data(bus_out), .ctl_oe(bus_oe),
    .data_bus(bus));
  always #4 clk = ~clk;
  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_sim;
    end
  end
  task automatic xfer(input logic w, input logic [13:0] a, input logic [15:0] d, input logic [1:0] be);
    integer n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
    req_valid = 1; req_write = w; req_addr = a; req_wdata = d; req_be = be;
    @(posedge clk); #1;
    req_valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
    if (n >= 50) failures++;
  endtask
  task automatic rd(input logic [13:0] a, input logic [15:0] e);
    xfer(0, a, 16'h0000, 2'h0);
    `CHK(rsp_rdata, e)
  endtask
  task automatic t_reset;
    repeat (3) @(posedge clk);
    #1;
    `CHK({sel_hi, sel_lo_n, write_n, out_en_n, lbs_n, hbs_n, bus_oe}, 7'h3e)
    `CHK({ale, dle}, 2'h3)
    $display("reset test done");
  endtask
  task automatic t_word;
    xfer(1, 14'h3fff, 16'ha5c3, 2'h3);
    xfer(1, 14'h0000, 16'h5a3c, 2'h3);
    rd(14'h3fff, 16'ha5c3);
    rd(14'h0000, 16'h5a3c);
    $display("word test done");
  endtask
  task automatic t_lanes;
    xfer(1, 14'h0005, 16'hffff, 2'h3);
    xfer(1, 14'h0005, 16'h1234, 2'h1);
    rd(14'h0005, 16'hff34);
    xfer(1, 14'h0005, 16'h5678, 2'h2);
    rd(14'h0005, 16'h5634);
    $display("lane test done");
  endtask
  task automatic t_abort;
    xfer(1, 14'h0005, 16'h0000, 2'h0);
    rd(14'h0005, 16'h5634);
    rd(14'h3fff, 16'ha5c3);
    $display("abort test done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 resetn = 1;
    t_reset;
    t_word;
    t_lanes;
    t_abort;
    end_sim;
  end
endmodule // lsc_ctrl_test
bind lsc_ctrl lsc_ctrl_asserts chk (.clk(clk), .resetn(resetn), .word_address(word_address),
  .sel_hi(sel_hi), .sel_lo_n(sel_lo_n), .write_n(write_n), .out_en_n(out_en_n),
  .low_byte_strobe_n(low_byte_strobe_n), .high_byte_strobe_n(high_byte_strobe_n),
  .addr_latch_open(addr_latch_open), .wdata_latch_open(wdata_latch_open),
  .data_io_bus_out(data_io_bus_out), .data_io_bus_oe(data_io_bus_oe));
